// ==== src/mdc_consts.vh ====
// constants for the multichannel dma channel control engine
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

// channel control register bit positions
`define MDC_BIT_ON 15
`define MDC_BIT_SIZE 14
`define MDC_BIT_DIR 13
`define MDC_BIT_HALF 12
`define MDC_BIT_NULL_WRITE_ENABLE 11
`define MDC_ADDRESSING_SELECT_HI 5
`define MDC_ADDRESSING_SELECT_LO 4
`define MDC_MODE_HI 1
`define MDC_MODE_LO 0
// implemented bits of the control register
`define MDC_CTRL_MASK 16'hF833
`define MDC_CTRL_RESET 16'h0000

// addressing select codes
`define MDC_AM_POSTINC 2'h0
`define MDC_AM_NOINC 2'h1
`define MDC_AM_PERIND 2'h2

// per channel word offsets (paddr[3:2]); channel n at byte 16*n
`define MDC_WD_CTRL 2'h0
`define MDC_WD_START 2'h1
`define MDC_WD_PADCNT 2'h2
`define MDC_WD_REQ 2'h3
// software trigger bit in the request word
`define MDC_BIT_TRIG 8

// global registers
`define MDC_ISTAT_ADDR 12'h080
`define MDC_IMASK_ADDR 12'h084

// byte lane enables
`define MDC_BE_WORD 2'h3
`define MDC_BE_LO 2'h1
`define MDC_BE_HI 2'h2

`endif

// ==== src/mdc_prio_arb.v ====
// fixed priority arbiter, request 0 has the highest priority
`timescale 1ns/1ps
`default_nettype none
module mdc_prio_arb (
  // requests
  input wire [7:0] req,
  // grant
  output reg gnt_any,
  output reg [2:0] gnt_idx
);
  integer i;

  // scan downward so the lowest index is the last to win
  always @*
  begin
    gnt_any = 1'b0;
    gnt_idx = 3'h0;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        gnt_any = 1'b1;
        gnt_idx = i[2:0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/mdc_dma_engine.v ====
// multichannel dma engine: apb registers, arbitration and transfers
`timescale 1ns/1ps
`default_nettype none
`include "mdc_consts.vh"
module mdc_dma_engine (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // dual port buffer ram
  output wire [15:0] ram_addr,
  output wire ram_re,
  output wire ram_we,
  output wire [1:0] ram_be,
  output wire [15:0] ram_wdata,
  input wire [15:0] ram_rdata,
  // peripheral register bus
  output wire [15:0] per_addr,
  output wire per_re,
  output wire per_we,
  output wire [1:0] per_be,
  output wire [15:0] per_wdata,
  input wire [15:0] per_rdata,
  input wire [15:0] per_ind_addr,
  // request sources
  input wire [63:0] req_src,
  // interrupts
  output wire [7:0] ch_irq,
  output wire irq
);
  localparam S_IDLE = 2'h0;
  localparam S_RD = 2'h1;
  localparam S_CAP = 2'h2;
  localparam S_WR = 2'h3;
  integer i;
  // channel registers
  reg [15:0] ctrl_reg [0:7];
  reg [15:0] sta_reg [0:7];
  reg [15:0] stb_reg [0:7];
  reg [15:0] pad_reg [0:7];
  reg [15:0] cnt_reg [0:7];
  reg [5:0] sel_reg [0:7];
  reg [15:0] idx_reg [0:7];
  reg [7:0] pp_reg;
  reg [7:0] pend_reg;
  reg [7:0] istat_reg;
  reg [7:0] imask_reg;
  reg [63:0] src_d_reg;
  // apb answer
  reg [31:0] prdata_reg;
  reg [31:0] rd_next;
  reg pready_reg, pslverr_reg;
  // engine
  reg [1:0] state_reg;
  reg [2:0] cur_reg;
  reg [15:0] ram_addr_reg, ram_wdata_reg, per_addr_reg, per_wdata_reg;
  reg ram_re_reg, ram_we_reg, per_re_reg, per_we_reg, irq_reg;
  reg [1:0] ram_be_reg, per_be_reg;
  reg [7:0] ch_irq_reg, ev_next;
  // apb decode; one wait state, answer on second access cycle
  wire apb_acc = psel & penable & ~pready_reg;
  wire apb_done = psel & penable & pready_reg;
  wire is_ch = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
  wire [2:0] a_ch = paddr[6:4];
  wire [1:0] a_wd = paddr[3:2];
  wire is_stat = (paddr == `MDC_ISTAT_ADDR);
  wire is_mask = (paddr == `MDC_IMASK_ADDR);
  wire mapped = is_ch | is_stat | is_mask;
  wire wr_ch = apb_done & pwrite & is_ch;
  wire stat_rd = apb_done & ~pwrite & is_stat;
  // request gating, one slice per channel; own index keeps one driver
  wire [7:0] chan_on;
  wire [7:0] rise;
  wire gnt_any;
  wire [2:0] gnt_idx;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_chan
      assign chan_on[g] = ctrl_reg[g][`MDC_BIT_ON];
      assign rise[g] = req_src[sel_reg[g]] & ~src_d_reg[sel_reg[g]];
    end
  endgenerate
  mdc_prio_arb u_arb (
    .req(pend_reg & chan_on),
    .gnt_any(gnt_any),
    .gnt_idx(gnt_idx)
  );

  // fields of the channel being started or serviced
  wire [2:0] ch = (state_reg == S_IDLE) ? gnt_idx : cur_reg;
  wire [15:0] c_ctrl = ctrl_reg[ch];
  wire c_byte = c_ctrl[`MDC_BIT_SIZE];
  wire c_dir = c_ctrl[`MDC_BIT_DIR];
  wire [1:0] c_am = c_ctrl[`MDC_ADDRESSING_SELECT_HI:`MDC_ADDRESSING_SELECT_LO];
  wire [1:0] c_mode = c_ctrl[`MDC_MODE_HI:`MDC_MODE_LO];
  wire [15:0] c_idx = idx_reg[ch];
  wire [15:0] c_base = pp_reg[ch] ? stb_reg[ch] : sta_reg[ch];
  wire [15:0] c_step = c_byte ? c_idx : {c_idx[14:0], 1'b0};
  wire [15:0] c_inc = c_base + c_step;
  // codes 10 and 11 both take the peripheral address
  wire [15:0] c_ram_addr = (c_am == `MDC_AM_POSTINC) ? c_inc :
    (c_am == `MDC_AM_NOINC) ? c_base : per_ind_addr;
  wire c_last = (c_idx == cnt_reg[ch]);
  wire c_half = (c_idx == {1'b0, cnt_reg[ch][15:1]});
  wire c_ev = c_ctrl[`MDC_BIT_HALF] ? c_half : c_last;
  // lane of a byte within the ram word
  wire lane_hi = ram_addr_reg[0];
  wire [7:0] ram_byte = lane_hi ? ram_rdata[15:8] : ram_rdata[7:0];

  // apb read mux; unimplemented bits come back as zero
  always @*
  begin
    rd_next = 32'h00000000;
    if (is_stat)
      rd_next = {24'h000000, istat_reg};
    else if (is_mask)
      rd_next = {24'h000000, imask_reg};
    else if (is_ch)
    begin
      case (a_wd)
        `MDC_WD_CTRL: rd_next = {16'h0000, ctrl_reg[a_ch]};
        `MDC_WD_START: rd_next = {stb_reg[a_ch], sta_reg[a_ch]};
        `MDC_WD_PADCNT: rd_next = {cnt_reg[a_ch], pad_reg[a_ch]};
        default: rd_next = {16'h0000, idx_reg[a_ch][7:0], 2'h0, sel_reg[a_ch]};
      endcase
    end
  end

  // apb answer registers
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc & ~mapped;
      if (apb_acc)
        prdata_reg <= pwrite ? 32'h00000000 : rd_next;
    end
  end

  // interrupt status: hardware set wins over the read clear
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_reg <= 8'h00;
      imask_reg <= 8'h00;
      irq_reg <= 1'b0;
      ch_irq_reg <= 8'h00;
    end
    else
    begin
      istat_reg <= (stat_rd ? 8'h00 : istat_reg) | ev_next;
      if (apb_done & pwrite & is_mask)
        imask_reg <= pwdata[7:0];
      irq_reg <= |(istat_reg & imask_reg);
      ch_irq_reg <= ev_next;
    end
  end

  // transfer sequencer: read source, capture, write destination
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE;
      cur_reg <= 3'h0;
      ram_addr_reg <= 16'h0000;
      ram_re_reg <= 1'b0;
      ram_we_reg <= 1'b0;
      ram_be_reg <= 2'h0;
      ram_wdata_reg <= 16'h0000;
      per_addr_reg <= 16'h0000;
      per_re_reg <= 1'b0;
      per_we_reg <= 1'b0;
      per_be_reg <= 2'h0;
      per_wdata_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (gnt_any)
          begin
            cur_reg <= gnt_idx;
            ram_addr_reg <= c_ram_addr;
            per_addr_reg <= pad_reg[gnt_idx];
            ram_be_reg <= ~c_byte ? `MDC_BE_WORD :
              (c_ram_addr[0] ? `MDC_BE_HI : `MDC_BE_LO);
            per_be_reg <= c_byte ? `MDC_BE_LO : `MDC_BE_WORD;
            ram_re_reg <= c_dir;
            per_re_reg <= ~c_dir;
            state_reg <= S_RD;
          end
        end
        S_RD:
        begin
          ram_re_reg <= 1'b0;
          per_re_reg <= 1'b0;
          state_reg <= S_CAP;
        end
        S_CAP:
        begin
          if (c_dir)
          begin
            // ram to peripheral, byte goes out in the low lane
            per_wdata_reg <= c_byte ? {8'h00, ram_byte} : ram_rdata;
            per_we_reg <= 1'b1;
          end
          else
          begin
            // peripheral to ram, byte copied to both lanes
            ram_wdata_reg <= c_byte ? {per_rdata[7:0], per_rdata[7:0]} :
              per_rdata;
            ram_we_reg <= 1'b1;
            per_wdata_reg <= 16'h0000;
            per_we_reg <= c_ctrl[`MDC_BIT_NULL_WRITE_ENABLE];
          end
          state_reg <= S_WR;
        end
        default:
        begin
          ram_we_reg <= 1'b0;
          per_we_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // block bookkeeping at the end of each transfer
  always @*
  begin
    ev_next = 8'h00;
    if (state_reg == S_WR && c_ev)
      ev_next[cur_reg] = 1'b1;
  end

  // channel registers, pending requests and block progress
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        ctrl_reg[i] <= `MDC_CTRL_RESET;
        sta_reg[i] <= 16'h0000;
        stb_reg[i] <= 16'h0000;
        pad_reg[i] <= 16'h0000;
        cnt_reg[i] <= 16'h0000;
        sel_reg[i] <= 6'h00;
        idx_reg[i] <= 16'h0000;
      end
      pp_reg <= 8'h00;
      pend_reg <= 8'h00;
      src_d_reg <= 64'h0000000000000000;
    end
    else
    begin
      src_d_reg <= req_src;
      // grant clears first so a new request in that cycle still counts
      for (i = 0; i < 8; i = i + 1)
      begin
        if (state_reg == S_IDLE && gnt_any && gnt_idx == i[2:0])
          pend_reg[i] <= 1'b0;
        if (chan_on[i] && rise[i])
          pend_reg[i] <= 1'b1;
      end
      if (state_reg == S_WR)
      begin
        if (c_last)
        begin
          idx_reg[cur_reg] <= 16'h0000;
          if (c_mode[1])
            pp_reg[cur_reg] <= ~pp_reg[cur_reg];
          // one-shot ping-pong stops after the second buffer
          if (c_mode[0] && (~c_mode[1] || pp_reg[cur_reg]))
            ctrl_reg[cur_reg][`MDC_BIT_ON] <= 1'b0;
        end
        else
          idx_reg[cur_reg] <= c_idx + 16'h0001;
      end
      // software writes override same cycle hardware updates
      if (wr_ch)
      begin
        case (a_wd)
          `MDC_WD_CTRL:
          begin
            ctrl_reg[a_ch] <= pwdata[15:0] & `MDC_CTRL_MASK;
            idx_reg[a_ch] <= 16'h0000;
            pp_reg[a_ch] <= 1'b0;
          end
          `MDC_WD_START:
          begin
            sta_reg[a_ch] <= pwdata[15:0];
            stb_reg[a_ch] <= pwdata[31:16];
          end
          `MDC_WD_PADCNT:
          begin
            pad_reg[a_ch] <= pwdata[15:0];
            cnt_reg[a_ch] <= pwdata[31:16];
          end
          default:
          begin
            sel_reg[a_ch] <= pwdata[5:0];
            if (pwdata[`MDC_BIT_TRIG] && chan_on[a_ch])
              pend_reg[a_ch] <= 1'b1;
          end
        endcase
      end
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ram_addr = ram_addr_reg;
  assign ram_re = ram_re_reg;
  assign ram_we = ram_we_reg;
  assign ram_be = ram_be_reg;
  assign ram_wdata = ram_wdata_reg;
  assign per_addr = per_addr_reg;
  assign per_re = per_re_reg;
  assign per_we = per_we_reg;
  assign per_be = per_be_reg;
  assign per_wdata = per_wdata_reg;
  assign ch_irq = ch_irq_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// ==== verification/mdc_dma_engine_properties.sv ====
// port level checks for the dma engine
`timescale 1ns/1ps
`default_nettype none
module mdc_dma_engine_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // transfer strobes and interrupts
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic per_re,
  input wire logic per_we,
  input wire logic [7:0] ch_irq,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // register answer always after one wait state
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // control word reads zero in unused bits
  chk_ctrl_zero: assert property (
    pready && !pwrite && paddr[11:7] == 5'h00 && paddr[3:0] == 4'h0
    |-> (prdata[15:0] & 16'h07CC) == 16'h0000)
    else $error("unused control bits set");
  // each direction reads one side and writes the other two cycles on
  chk_ram_path: assert property (ram_re |-> ##2 per_we)
    else $error("ram read not followed by peripheral write");
  chk_per_path: assert property (per_re |-> ##2 ram_we)
    else $error("peripheral read not followed by ram write");
  chk_xfer_gap: assert property ((ram_re || per_re) |=>
    !(ram_re || per_re) [*3])
    else $error("transfers closer than four cycles");
  // events only follow a completed write; irq moves with status
  chk_event_src: assert property (|ch_irq |-> $past(ram_we || per_we))
    else $error("event without transfer");
  chk_irq_rise: assert property ($rose(irq) |->
    $past(|ch_irq) || $past(pready, 2))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(pready, 2))
    else $error("irq fell without register access");
  cover property (|ch_irq);
  cover property (pslverr);
  cover property (irq);
endmodule
bind mdc_dma_engine mdc_dma_engine_properties i_mdc_dma_engine_properties (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ram_re(ram_re), .ram_we(ram_we), .per_re(per_re),
  .per_we(per_we), .ch_irq(ch_irq), .irq(irq));
`default_nettype wire

// ==== verification/mdc_periph_model.sv ====
// buffer ram and peripheral register model at the far side
`timescale 1ns/1ps
`default_nettype none
module mdc_periph_model (
  // clock
  input wire logic clk_sys,
  // buffer ram
  input wire logic [15:0] ram_addr,
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic [1:0] ram_be,
  input wire logic [15:0] ram_wdata,
  output logic [15:0] ram_rdata,
  // peripheral register
  input wire logic [15:0] per_addr,
  input wire logic per_re,
  input wire logic per_we,
  input wire logic [15:0] per_wdata,
  output logic [15:0] per_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last_addr;
  logic [15:0] last_data;
  // sync read; idle buses invert so stale data never passes
  always @(posedge clk_sys)
  begin
    ram_rdata <= ram_re ? mem[ram_addr[8:1]] : ~ram_rdata;
    per_rdata <= per_re ? {8'hC3, per_addr[7:0]} : ~per_rdata;
    if (ram_we && ram_be[0])
      mem[ram_addr[8:1]][7:0] <= ram_wdata[7:0];
    if (ram_we && ram_be[1])
      mem[ram_addr[8:1]][15:8] <= ram_wdata[15:8];
    if (per_we)
    begin
      last_addr <= per_addr;
      last_data <= per_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== verification/mdc_dma_engine_test.sv ====
// testbench for the dma engine
`timescale 1ns/1ps
`default_nettype none
`include "mdc_consts.vh"
module mdc_dma_engine_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] per_ind_addr = 16'h0000;
  logic [63:0] req_src = 64'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ram_re, ram_we, per_re, per_we, irq;
  wire logic [15:0] ram_addr, ram_wdata, ram_rdata;
  wire logic [15:0] per_addr, per_wdata, per_rdata;
  wire logic [1:0] ram_be, per_be;
  logic [7:0] ev_seen = 8'h00;
  wire logic [7:0] ch_irq;
  int n_fail = 0, n_compared = 0;
  mdc_dma_engine i_mdc_dma_engine (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we), .ram_be(ram_be),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .per_addr(per_addr),
    .per_re(per_re), .per_we(per_we), .per_be(per_be), .per_wdata(per_wdata),
    .per_rdata(per_rdata), .per_ind_addr(per_ind_addr), .req_src(req_src),
    .ch_irq(ch_irq), .irq(irq));
  mdc_periph_model i_mdc_periph_model (.clk_sys(clk_sys),
    .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we), .ram_be(ram_be),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .per_addr(per_addr),
    .per_re(per_re), .per_we(per_we), .per_wdata(per_wdata),
    .per_rdata(per_rdata));
  // 25 mhz system clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  // sticky record of channel event pulses; skipped in reset, outputs unknown
  always @(posedge clk_sys)
  begin
    if (rst_n)
      ev_seen <= ev_seen | ch_irq;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one apb transfer; waits for pready, never assumes its latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      chk("apb ready", 32'h0, 32'h1);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task t_regs;
    apb(0, 12'h000, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1, 12'h010, 32'hFFFF);
    apb(0, 12'h010, 32'h0);
    chk("ctrl mask", rd, 32'h0000F833);
    apb(1, 12'h010, 32'h0);
    apb(0, 12'h0FC, 32'h0);
    chk("unmapped", er, 32'h1);
    $display("test regs done");
  endtask
  task t_ram2per;
    i_mdc_periph_model.mem[8] = 16'h1111;
    i_mdc_periph_model.mem[9] = 16'h2222;
    apb(1, `MDC_IMASK_ADDR, 32'h01);
    apb(1, 12'h004, 32'h0010);
    apb(1, 12'h008, 32'h00010200);
    apb(1, 12'h000, 32'hA001);
    repeat (2)
    begin
      apb(1, 12'h00C, 32'h100);
      idle(8);
    end
    chk("per data", i_mdc_periph_model.last_data, 32'h2222);
    chk("per addr", i_mdc_periph_model.last_addr, 32'h0200);
    apb(0, 12'h000, 32'h0);
    chk("one shot off", rd, 32'h2001);
    chk("irq up", irq, 32'h1);
    apb(0, `MDC_ISTAT_ADDR, 32'h0);
    chk("status", rd, 32'h1);
    idle(2);
    chk("irq down", irq, 32'h0);
    chk("ch event", ev_seen, 32'h01);
    $display("test ram to peripheral done");
  endtask
  task t_per2ram;
    i_mdc_periph_model.mem[24] = 16'h0000;
    per_ind_addr <= 16'h0031;
    apb(1, 12'h018, 32'h0240);
    apb(1, 12'h01C, 32'h5);
    apb(1, 12'h010, 32'hC821);
    @(posedge clk_sys);
    req_src[5] <= 1'b1;
    idle(8);
    chk("ram byte", i_mdc_periph_model.mem[24], 32'h4000);
    chk("null data", i_mdc_periph_model.last_data, 32'h0);
    chk("masked irq", irq, 32'h0);
    chk("byte lanes", per_be, 32'h1);
    chk("ch event", ev_seen, 32'h03);
    $display("test peripheral to ram done");
  endtask
  task t_prio;
    for (int c = 2; c < 4; c++)
    begin
      apb(1, 12'(16 * c + 4), 32'h0010);
      apb(1, 12'(16 * c + 8), 32'h0200 + c);
      apb(1, 12'(16 * c + 12), 32'h7);
      apb(1, 12'(16 * c), 32'hA000);
    end
    @(posedge clk_sys);
    req_src[7] <= 1'b1;
    idle(12);
    chk("grant order", i_mdc_periph_model.last_addr, 32'h0203);
    chk("word lanes", per_be, 32'h3);
    chk("ch event", ev_seen, 32'h0F);
    $display("test priority done");
  endtask
  // one-shot ping-pong, half block events, no increment on channel 4
  task t_pingpong;
    i_mdc_periph_model.mem[32] = 16'hAAAA;
    i_mdc_periph_model.mem[48] = 16'hBBBB;
    apb(1, 12'h044, 32'h00600040);
    apb(1, 12'h048, 32'h00010300);
    apb(1, 12'h040, 32'hB013);
    apb(1, 12'h04C, 32'h100);
    idle(8);
    chk("half event", ev_seen, 32'h1F);
    apb(1, 12'h04C, 32'h100);
    idle(8);
    chk("buffer a", i_mdc_periph_model.last_data, 32'hAAAA);
    apb(0, 12'h040, 32'h0);
    chk("pp still on", rd, 32'hB013);
    // third trigger finds the channel off and must be dropped
    repeat (3)
    begin
      apb(1, 12'h04C, 32'h100);
      idle(8);
    end
    chk("buffer b", i_mdc_periph_model.last_data, 32'hBBBB);
    apb(0, 12'h040, 32'h0);
    chk("pp one shot", rd, 32'h3013);
    $display("test ping-pong done");
  endtask
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_ram2per;
    t_per2ram;
    t_prio;
    t_pingpong;
    give_verdict;
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    chk("watchdog", 32'h0, 32'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
